//--- core/ppas_top.sv
// Parallel port destination address, pin enables, slave buffer status and APB slave
//
// Local design decisions: the APB interface to the registers and the register addresses.
`default_nettype none
//////////////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Address register, bit 14 is chip select
// - Line 14 enable routes pin to port
// - Line 10..2 enables route address pins
// - Lines 1..0 enables route address/latch pins
// - Input full summary when all slots full
// - Sticky overflow on write to full slot
// - Slot full flags, cleared by software read
// - Output empty summary when all slots empty
// - Sticky underflow on read of empty slot
// - Slot empty flags, cleared by software write
// - Pad bit selects TTL or Schmitt receivers
// - Unimplemented bits ignore writes, read zero
// - Mode 11 interrupts on slot 3 access
// - Step address 10:0 per cycle, inc/dec
// - Enhanced slave uses address lines for slot
module ppas_top
  import ppas_pkg::*;
#(
  parameter int NBUF = PPAS_NBUF
) (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic HOST_RD,
  input wire logic HOST_WR,
  input wire logic HOST_CS,
  input wire logic [1:0] HOST_ADDR,
  input wire logic [7:0] HOST_DIN,
  output logic [7:0] HOST_DOUT,
  output logic HOST_DOE_N,
  input wire logic MASTER_CYCLE_DONE,
  output logic [15:0] ADDR_PIN_OUT,
  output logic [15:0] PIN_FUNC_SEL,
  output logic CHIP_SELECT,
  output logic INPUT_TTL_SEL,
  output logic IRQ
);

  if (NBUF != 4) begin : g_bad_nbuf
    $error("ppas_top: slot index is two address lines, NBUF must be 4");
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // Host pin synchronisers
  ppas_host_pins_t raw_pins;
  ppas_host_pins_t sync1_ff, sync2_ff, prev_ff;
  logic host_wr_end, host_rd_start;

  always_comb begin
    raw_pins.rd = HOST_RD;
    raw_pins.wr = HOST_WR;
    raw_pins.cs = HOST_CS;
    raw_pins.addr = HOST_ADDR;
    raw_pins.data = HOST_DIN;
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      prev_ff <= '0;
    end else begin
      sync1_ff <= raw_pins;
      sync2_ff <= sync1_ff;
      prev_ff <= sync2_ff;
    end
  end

  // A write is taken as the strobe falls, so the data has settled for the whole strobe
  assign host_wr_end = prev_ff.wr & ~sync2_ff.wr & prev_ff.cs;
  assign host_rd_start = sync2_ff.rd & ~prev_ff.rd & sync2_ff.cs;

  //////////////////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state so that read data leaves a flip-flop
  logic pready_ff, nxt_pready;
  logic pslverr_ff, nxt_pslverr;
  logic [31:0] prdata_ff, nxt_prdata;
  logic apb_done, sw_wr, sw_rd;
  logic [31:0] rd_value;
  logic rd_unmapped;
  logic in_buf_hit, out_buf_hit;
  logic [1:0] buf_sel;

  // Register state
  logic [15:0] dest_ff, nxt_dest;
  logic [15:0] pen_ff, nxt_pen;
  logic [15:0] pad_ff, nxt_pad;
  ppas_ctrl_t ctrl_ff, nxt_ctrl;
  logic [2:0] irq_stat_ff, nxt_irq_stat;
  logic [2:0] irq_mask_ff, nxt_irq_mask;
  logic ovf_ff, nxt_ovf;
  logic unf_ff, nxt_unf;
  logic [NBUF-1:0] in_full_ff, nxt_in_full;
  logic [NBUF-1:0] out_empty_ff, nxt_out_empty;
  logic [NBUF-1:0][7:0] in_buf_ff, nxt_in_buf;
  logic [NBUF-1:0][7:0] out_buf_ff, nxt_out_buf;
  logic [1:0] in_ptr_ff, nxt_in_ptr;
  logic [1:0] out_ptr_ff, nxt_out_ptr;
  logic [7:0] dout_ff, nxt_dout;
  logic doe_n_ff, nxt_doe_n;
  logic chip_sel_ff, nxt_chip_sel;
  logic irq_ff, nxt_irq;
  logic [15:0] status_word;

  assign apb_done = PSEL & PENABLE & pready_ff;
  assign sw_wr = apb_done & PWRITE;
  assign sw_rd = apb_done & ~PWRITE;
  assign in_buf_hit = (PADDR[7:4] == PPAS_OFF_INBUF[7:4]) && (PADDR[1:0] == 2'h0);
  assign out_buf_hit = (PADDR[7:4] == PPAS_OFF_OUTBUF[7:4]) && (PADDR[1:0] == 2'h0);
  assign buf_sel = PADDR[3:2];

  // Summaries are live combinations, never a stored copy that could lag
  always_comb begin
    status_word = 16'h0000;
    status_word[PPAS_IBF_BIT] = &in_full_ff;
    status_word[PPAS_INPUT_OVERFLOW_FLAG_BIT] = ovf_ff;
    status_word[PPAS_IBXF_LSB +: 4] = in_full_ff;
    status_word[PPAS_OBE_BIT] = &out_empty_ff;
    status_word[PPAS_OUTPUT_UNDERFLOW_FLAG_BIT] = unf_ff;
    status_word[PPAS_OBXE_LSB +: 4] = out_empty_ff;
  end

  always_comb begin
    rd_value = 32'h0000_0000;
    rd_unmapped = 1'b0;
    if (PADDR == PPAS_OFF_DEST) begin
      rd_value[15:0] = dest_ff;
    end else if (PADDR == PPAS_OFF_PEN) begin
      rd_value[15:0] = pen_ff & PPAS_PEN_MASK;
    end else if (PADDR == PPAS_OFF_STAT) begin
      rd_value[15:0] = status_word;
    end else if (PADDR == PPAS_OFF_PAD) begin
      rd_value[15:0] = pad_ff & PPAS_PAD_MASK;
    end else if (PADDR == PPAS_OFF_CTRL) begin
      rd_value[6:0] = ctrl_ff;
    end else if (PADDR == PPAS_OFF_ISTAT) begin
      rd_value[2:0] = irq_stat_ff;
    end else if (PADDR == PPAS_OFF_IMASK) begin
      rd_value[2:0] = irq_mask_ff;
    end else if (in_buf_hit) begin
      rd_value[7:0] = in_buf_ff[buf_sel];
    end else if (out_buf_hit) begin
      rd_value[7:0] = out_buf_ff[buf_sel];
    end else begin
      rd_unmapped = 1'b1;
    end
  end

  always_comb begin
    nxt_pready = PSEL & PENABLE & ~pready_ff;
    nxt_pslverr = 1'b0;
    nxt_prdata = prdata_ff;
    if (PSEL & PENABLE & ~pready_ff) begin
      nxt_pslverr = rd_unmapped;
      nxt_prdata = PWRITE ? 32'h0000_0000 : rd_value;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      prdata_ff <= nxt_prdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // Registers, slave buffers and interrupt status
  logic [1:0] host_in_idx, host_out_idx;
  logic host_rd_ok, host_evt, buf3_evt;
  logic ovf_evt, unf_evt;
  logic [2:0] irq_evt;
  logic rotate;

  always_comb begin
    nxt_dest = dest_ff;
    nxt_pen = pen_ff;
    nxt_pad = pad_ff;
    nxt_ctrl = ctrl_ff;
    nxt_irq_mask = irq_mask_ff;
    nxt_irq_stat = irq_stat_ff;
    nxt_ovf = ovf_ff;
    nxt_unf = unf_ff;
    nxt_in_full = in_full_ff;
    nxt_out_empty = out_empty_ff;
    nxt_in_buf = in_buf_ff;
    nxt_out_buf = out_buf_ff;
    nxt_in_ptr = in_ptr_ff;
    nxt_out_ptr = out_ptr_ff;
    nxt_dout = dout_ff;
    nxt_doe_n = ~(sync2_ff.rd & sync2_ff.cs);
    ovf_evt = 1'b0;
    unf_evt = 1'b0;
    host_rd_ok = 1'b0;
    rotate = (ctrl_ff.step_mode == PPAS_STEP_ROTATE) &&
             (ctrl_ff.slave_mode == PPAS_SLAVE_LEGACY);
    // Enhanced mode picks the slot by address lines, otherwise the rotating pointer
    host_in_idx = (ctrl_ff.slave_mode == PPAS_SLAVE_ENHANCED) ? prev_ff.addr : in_ptr_ff;
    host_out_idx = (ctrl_ff.slave_mode == PPAS_SLAVE_ENHANCED) ? sync2_ff.addr
                                                                : out_ptr_ff;

    // Software writes; masks keep unimplemented bits at zero
    if (sw_wr) begin
      if (PADDR == PPAS_OFF_DEST) begin
        nxt_dest = PWDATA[15:0];
      end else if (PADDR == PPAS_OFF_PEN) begin
        nxt_pen = PWDATA[15:0] & PPAS_PEN_MASK;
      end else if (PADDR == PPAS_OFF_STAT) begin
        nxt_ovf = PWDATA[PPAS_INPUT_OVERFLOW_FLAG_BIT];
        nxt_unf = PWDATA[PPAS_OUTPUT_UNDERFLOW_FLAG_BIT];
      end else if (PADDR == PPAS_OFF_PAD) begin
        nxt_pad = PWDATA[15:0] & PPAS_PAD_MASK;
      end else if (PADDR == PPAS_OFF_CTRL) begin
        nxt_ctrl = PWDATA[6:0];
      end else if (PADDR == PPAS_OFF_IMASK) begin
        nxt_irq_mask = PWDATA[2:0];
      end
    end

    // Address stepping; a software write in the same cycle takes priority
    if (MASTER_CYCLE_DONE && !(sw_wr && PADDR == PPAS_OFF_DEST)) begin
      if (ctrl_ff.step_mode == PPAS_STEP_INC) begin
        nxt_dest[PPAS_STEP_MSB:0] = dest_ff[PPAS_STEP_MSB:0] + 11'h001;
      end else if (ctrl_ff.step_mode == PPAS_STEP_DEC) begin
        nxt_dest[PPAS_STEP_MSB:0] = dest_ff[PPAS_STEP_MSB:0] - 11'h001;
      end
    end

    // Software drains input slots and fills output slots
    if (sw_rd && in_buf_hit) begin
      nxt_in_full[buf_sel] = 1'b0;
    end

    // Host write into an input slot; a full slot keeps its data
    if (host_wr_end) begin
      if (in_full_ff[host_in_idx]) begin
        ovf_evt = 1'b1;
      end else begin
        nxt_in_buf[host_in_idx] = prev_ff.data;
        nxt_in_full[host_in_idx] = 1'b1;
      end
      if (rotate) begin
        nxt_in_ptr = in_ptr_ff + 2'h1;
      end
    end

    // Host read of an output slot
    if (host_rd_start) begin
      if (out_empty_ff[host_out_idx]) begin
        unf_evt = 1'b1;
      end else begin
        host_rd_ok = 1'b1;
        nxt_dout = out_buf_ff[host_out_idx];
        nxt_out_empty[host_out_idx] = 1'b1;
      end
      if (rotate) begin
        nxt_out_ptr = out_ptr_ff + 2'h1;
      end
    end

    // A software fill after a same-cycle host read leaves the new data pending
    if (sw_wr && out_buf_hit) begin
      nxt_out_buf[buf_sel] = PWDATA[7:0];
      nxt_out_empty[buf_sel] = 1'b0;
    end

    // Hardware set wins over a software clear in the same cycle
    if (ovf_evt) begin
      nxt_ovf = 1'b1;
    end
    if (unf_evt) begin
      nxt_unf = 1'b1;
    end

    host_evt = host_wr_end | host_rd_start;
    buf3_evt = (host_wr_end && host_in_idx == PPAS_LAST_SLOT) ||
               (host_rd_start && host_out_idx == PPAS_LAST_SLOT);
    irq_evt = 3'h0;
    irq_evt[PPAS_IRQ_OVF] = ovf_evt;
    irq_evt[PPAS_IRQ_UNF] = unf_evt;
    if (ctrl_ff.irq_mode == PPAS_IRQM_CYCLE) begin
      irq_evt[PPAS_IRQ_REQ] = host_evt | MASTER_CYCLE_DONE;
    end else if (ctrl_ff.irq_mode == PPAS_IRQM_BUF3) begin
      irq_evt[PPAS_IRQ_REQ] = buf3_evt;
    end

    // Read clears only what was shown to software, so a new event is not lost
    if (sw_rd && PADDR == PPAS_OFF_ISTAT) begin
      nxt_irq_stat = irq_stat_ff & ~prdata_ff[2:0];
    end
    nxt_irq_stat = nxt_irq_stat | irq_evt;
    nxt_irq = |(nxt_irq_stat & nxt_irq_mask);
    nxt_chip_sel = nxt_dest[PPAS_CS1_BIT] & nxt_ctrl.cs_is_select & nxt_pen[PPAS_CS1_BIT];
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      dest_ff <= PPAS_RST_DEST;
      pen_ff <= PPAS_RST_PEN;
      pad_ff <= PPAS_RST_PAD;
      ctrl_ff <= PPAS_RST_CTRL;
      irq_stat_ff <= PPAS_RST_IRQ;
      irq_mask_ff <= PPAS_RST_IRQ;
      ovf_ff <= 1'b0;
      unf_ff <= 1'b0;
      in_full_ff <= PPAS_RST_IN_FULL;
      out_empty_ff <= PPAS_RST_OUT_EMPTY;
      in_buf_ff <= '0;
      out_buf_ff <= '0;
      in_ptr_ff <= 2'h0;
      out_ptr_ff <= 2'h0;
      dout_ff <= 8'h00;
      doe_n_ff <= 1'b1;
      chip_sel_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      dest_ff <= nxt_dest;
      pen_ff <= nxt_pen;
      pad_ff <= nxt_pad;
      ctrl_ff <= nxt_ctrl;
      irq_stat_ff <= nxt_irq_stat;
      irq_mask_ff <= nxt_irq_mask;
      ovf_ff <= nxt_ovf;
      unf_ff <= nxt_unf;
      in_full_ff <= nxt_in_full;
      out_empty_ff <= nxt_out_empty;
      in_buf_ff <= nxt_in_buf;
      out_buf_ff <= nxt_out_buf;
      in_ptr_ff <= nxt_in_ptr;
      out_ptr_ff <= nxt_out_ptr;
      dout_ff <= nxt_dout;
      doe_n_ff <= nxt_doe_n;
      chip_sel_ff <= nxt_chip_sel;
      irq_ff <= nxt_irq;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from flip-flops
  assign PRDATA = prdata_ff;
  assign PREADY = pready_ff;
  assign PSLVERR = pslverr_ff;
  assign HOST_DOUT = dout_ff;
  assign HOST_DOE_N = doe_n_ff;
  assign ADDR_PIN_OUT = dest_ff;
  assign PIN_FUNC_SEL = pen_ff;
  assign CHIP_SELECT = chip_sel_ff;
  assign INPUT_TTL_SEL = pad_ff[PPAS_TTL_BIT];
  assign IRQ = irq_ff;

endmodule
`default_nettype wire

//--- core/ppas_pkg.sv
// Constants, register map and carrier types of the parallel port address/status block
`default_nettype none
package ppas_pkg;
  localparam int PPAS_NBUF = 4;
  // Register byte offsets on the APB
  localparam logic [7:0] PPAS_OFF_DEST = 8'h00;
  localparam logic [7:0] PPAS_OFF_PEN = 8'h04;
  localparam logic [7:0] PPAS_OFF_STAT = 8'h08;
  localparam logic [7:0] PPAS_OFF_PAD = 8'h0C;
  localparam logic [7:0] PPAS_OFF_CTRL = 8'h10;
  localparam logic [7:0] PPAS_OFF_ISTAT = 8'h14;
  localparam logic [7:0] PPAS_OFF_IMASK = 8'h18;
  localparam logic [7:0] PPAS_OFF_INBUF = 8'h20;
  localparam logic [7:0] PPAS_OFF_OUTBUF = 8'h30;
  // Values after reset
  localparam logic [15:0] PPAS_RST_DEST = 16'h0000;
  localparam logic [15:0] PPAS_RST_PEN = 16'h0000;
  localparam logic [15:0] PPAS_RST_PAD = 16'h0000;
  localparam logic [3:0] PPAS_RST_IN_FULL = 4'h0;
  localparam logic [3:0] PPAS_RST_OUT_EMPTY = 4'hF;
  localparam logic [6:0] PPAS_RST_CTRL = 7'h00;
  localparam logic [2:0] PPAS_RST_IRQ = 3'h0;
  // Writable bit masks
  localparam logic [15:0] PPAS_PEN_MASK = 16'h47FF;
  localparam logic [15:0] PPAS_PAD_MASK = 16'h0001;
  // Field positions
  localparam int PPAS_CS1_BIT = 14;
  localparam int PPAS_TTL_BIT = 0;
  localparam int PPAS_IBF_BIT = 15;
  localparam int PPAS_INPUT_OVERFLOW_FLAG_BIT = 14;
  localparam int PPAS_IBXF_LSB = 8;
  localparam int PPAS_OBE_BIT = 7;
  localparam int PPAS_OUTPUT_UNDERFLOW_FLAG_BIT = 6;
  localparam int PPAS_OBXE_LSB = 0;
  localparam int PPAS_STEP_MSB = 10;
  localparam int PPAS_IRQ_REQ = 0;
  localparam int PPAS_IRQ_OVF = 1;
  localparam int PPAS_IRQ_UNF = 2;
  // Mode codes
  localparam logic [1:0] PPAS_IRQM_NONE = 2'h0;
  localparam logic [1:0] PPAS_IRQM_CYCLE = 2'h1;
  localparam logic [1:0] PPAS_IRQM_STALL = 2'h2;
  localparam logic [1:0] PPAS_IRQM_BUF3 = 2'h3;
  localparam logic [1:0] PPAS_STEP_NONE = 2'h0;
  localparam logic [1:0] PPAS_STEP_INC = 2'h1;
  localparam logic [1:0] PPAS_STEP_DEC = 2'h2;
  localparam logic [1:0] PPAS_STEP_ROTATE = 2'h3;
  localparam logic [1:0] PPAS_SLAVE_LEGACY = 2'h0;
  localparam logic [1:0] PPAS_SLAVE_ENHANCED = 2'h1;
  localparam logic [1:0] PPAS_LAST_SLOT = 2'h3;

  typedef struct packed {
    logic rd;
    logic wr;
    logic cs;
    logic [1:0] addr;
    logic [7:0] data;
  } ppas_host_pins_t;

  typedef struct packed {
    logic cs_is_select;
    logic [1:0] slave_mode;
    logic [1:0] step_mode;
    logic [1:0] irq_mode;
  } ppas_ctrl_t;
endpackage
`default_nettype wire

//--- dv/ppas_sva.sv
// Port assertions for the parallel port address/status block
`default_nettype none
module ppas_sva(
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic [15:0] ADDR_PIN_OUT,
  input wire logic [15:0] PIN_FUNC_SEL,
  input wire logic CHIP_SELECT,
  input wire logic INPUT_TTL_SEL,
  input wire logic HOST_RD,
  input wire logic HOST_CS,
  input wire logic HOST_DOE_N
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  logic wr_done;
  // Two edges allowed so an extra output flop does not trip the checks
  assign wr_done = PSEL && PENABLE && PREADY && PWRITE;
  ready_pulse_a: assert property (PREADY |=> !PREADY)
    else $error("ready held past one cycle");
  ready_time_a: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("ready late in access phase");
  err_ready_a: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  dest_wr_a: assert property (
    wr_done && PADDR == 8'h00 |=> ##1 ADDR_PIN_OUT == $past(PWDATA[15:0], 2))
    else $error("address pins differ from write");
  pen_wr_a: assert property (
    wr_done && PADDR == 8'h04 |=> ##1 PIN_FUNC_SEL == ($past(PWDATA[15:0], 2) & 16'h47FF))
    else $error("pin enables differ from write");
  pen_mask_a: assert property ((PIN_FUNC_SEL & 16'hB800) == 16'h0000)
    else $error("unimplemented enable bit set");
  cs_cause_a: assert property (
    $rose(CHIP_SELECT) |-> ADDR_PIN_OUT[14] && PIN_FUNC_SEL[14])
    else $error("select without address bit and enable");
  pad_wr_a: assert property (
    wr_done && PADDR == 8'h0C |=> ##1 INPUT_TTL_SEL == $past(PWDATA[0], 2))
    else $error("receiver select differs from write");
  // Enable follows read and select three edges late: two sync flops plus the output flop
  read_enable_a: assert property (
    HOST_DOE_N == !($past(HOST_RD, 3) && $past(HOST_CS, 3)))
    else $error("data enable does not follow host read");
  dest_c: cover property (wr_done && PADDR == 8'h00);
  err_c: cover property (PSLVERR);
  cs_c: cover property ($rose(CHIP_SELECT));
  drive_c: cover property ($fell(HOST_DOE_N));
endmodule
bind ppas_top ppas_sva chk(.CLOCK(CLOCK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .ADDR_PIN_OUT(ADDR_PIN_OUT), .PIN_FUNC_SEL(PIN_FUNC_SEL), .CHIP_SELECT(CHIP_SELECT),
  .INPUT_TTL_SEL(INPUT_TTL_SEL), .HOST_RD(HOST_RD), .HOST_CS(HOST_CS),
  .HOST_DOE_N(HOST_DOE_N));
`default_nettype wire

//--- dv/ppas_host.sv
// Behavioural external host driving the slave strobes
`default_nettype none
module ppas_host(
  input wire logic clk,
  input wire logic go,
  input wire logic rd,
  input wire logic [1:0] slot,
  input wire logic [7:0] din,
  output logic busy,
  output logic hrd,
  output logic hwr,
  output logic hcs,
  output logic [1:0] haddr,
  output logic [7:0] hdata
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  initial begin
    {busy, hrd, hwr, hcs, haddr} = 6'h00;
    hdata = 8'hA5;
  end
  always @(posedge clk) begin
    if (go && !busy) begin
      busy <= 1'b1;
      cnt <= 0;
      hcs <= 1'b1;
      haddr <= slot;
      hdata <= rd ? ~hdata : din;
      hrd <= rd;
      hwr <= !rd;
    end else if (busy) begin
      cnt <= cnt + 1;
      if (cnt == 3) begin
        hrd <= 1'b0;
        hwr <= 1'b0;
      end
      if (cnt == 6) begin // Released bus shows the inverse, never a stale value
        hcs <= 1'b0;
        hdata <= ~hdata;
      end
      if (cnt == 9) busy <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- dv/testbench.sv
// Self-checking bench for the parallel port address/status block
`default_nettype none
module testbench
  import ppas_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLOCK = 0, RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, MCD = 0, go = 0, hrd = 0;
  logic [7:0] PADDR = 8'h00, hdin = 8'h00, HOST_DIN, HOST_DOUT;
  logic [31:0] PWDATA = 32'h0, PRDATA;
  logic PREADY, PSLVERR, HOST_RD, HOST_WR, HOST_CS, HOST_DOE_N, CHIP_SELECT, INPUT_TTL_SEL;
  logic IRQ, busy;
  logic [1:0] HOST_ADDR, slot = 2'h0;
  logic [15:0] ADDR_PIN_OUT, PIN_FUNC_SEL, r;
  logic [32:0] expq[$];
  logic [7:0] d[4];
  int n_fail = 0, checks = 0, cyc = 0, seed = 32'hD9CC36D4;
  ppas_top uut(.CLOCK(CLOCK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .HOST_RD(HOST_RD), .HOST_WR(HOST_WR), .HOST_CS(HOST_CS), .HOST_ADDR(HOST_ADDR),
    .HOST_DIN(HOST_DIN), .HOST_DOUT(HOST_DOUT), .HOST_DOE_N(HOST_DOE_N),
    .MASTER_CYCLE_DONE(MCD), .ADDR_PIN_OUT(ADDR_PIN_OUT), .PIN_FUNC_SEL(PIN_FUNC_SEL),
    .CHIP_SELECT(CHIP_SELECT), .INPUT_TTL_SEL(INPUT_TTL_SEL), .IRQ(IRQ));
  ppas_host host_m(.clk(CLOCK), .go(go), .rd(hrd), .slot(slot), .din(hdin), .busy(busy),
    .hrd(HOST_RD), .hwr(HOST_WR), .hcs(HOST_CS), .haddr(HOST_ADDR), .hdata(HOST_DIN));
  initial forever #50 CLOCK = ~CLOCK;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t bus got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic pin(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t pins got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v,
    input logic [32:0] e);
    @(posedge CLOCK);
    expq.push_back(e);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= v;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    do @(posedge CLOCK); while (PREADY !== 1'b1);
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    apb(1'b1, a, v, 33'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, {1'b0, e});
  endtask
  task automatic wt;
    repeat (2) @(posedge CLOCK);
    #1;
  endtask
  task automatic host(input logic rdn, input logic [1:0] s, input logic [7:0] v);
    @(posedge CLOCK);
    go <= 1'b1;
    hrd <= rdn;
    slot <= s;
    hdin <= v;
    @(posedge CLOCK);
    go <= 1'b0;
    do @(posedge CLOCK); while (busy);
  endtask
  task automatic step(input logic [15:0] e);
    @(posedge CLOCK);
    MCD <= 1'b1;
    @(posedge CLOCK);
    MCD <= 1'b0;
    wt;
    pin(ADDR_PIN_OUT, e);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge CLOCK) begin
    if (PSEL && PENABLE && PREADY === 1'b1) begin
      if (expq.size() == 0) cmp(33'h1FFFFFFFF, 33'h0);
      else cmp({PSLVERR, PRDATA}, expq.pop_front());
    end
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      stop_test;
    end
  end
  initial begin
    repeat (10) @(posedge CLOCK);
    RST <= 1'b0;
    rd(PPAS_OFF_STAT, 32'h008F);
    rd(PPAS_OFF_DEST, 32'h0);
    for (int i = 0; i < 2; i++) begin
      r = 16'($random(seed));
      wr(PPAS_OFF_DEST, {16'hFFFF, r});
      rd(PPAS_OFF_DEST, {16'h0, r});
      wt;
      pin(ADDR_PIN_OUT, r);
    end
    wr(PPAS_OFF_PEN, 32'hFFFF);
    rd(PPAS_OFF_PEN, 32'h47FF);
    wr(PPAS_OFF_PAD, 32'hFFFF);
    rd(PPAS_OFF_PAD, 32'h1);
    wt;
    pin({INPUT_TTL_SEL, PIN_FUNC_SEL[14:0]}, 16'hC7FF);
    wr(PPAS_OFF_PAD, 32'h0);
    wr(PPAS_OFF_CTRL, 32'h50);
    wr(PPAS_OFF_DEST, 32'h4000);
    wt;
    pin({CHIP_SELECT, 14'h0, INPUT_TTL_SEL}, 16'h8000);
    wr(PPAS_OFF_PEN, 32'h0);
    wt;
    pin({CHIP_SELECT, PIN_FUNC_SEL[14:0]}, 16'h0);
    apb(1'b0, 8'h1C, 32'h0, {1'b1, 32'h0});
    $display("test registers done");
    wr(PPAS_OFF_CTRL, 32'h54);
    wr(PPAS_OFF_DEST, 32'h87FF);
    step(16'h8000);
    wr(PPAS_OFF_CTRL, 32'h58);
    step(16'h87FF);
    $display("test step done");
    wr(PPAS_OFF_CTRL, 32'h50);
    wr(PPAS_OFF_IMASK, 32'h7);
    for (int i = 0; i < 4; i++) begin
      d[i] = 8'($random(seed));
      host(1'b0, 2'(i), d[i]);
    end
    rd(PPAS_OFF_STAT, 32'h8F8F);
    host(1'b0, 2'h0, 8'h3C);
    rd(PPAS_OFF_STAT, 32'hCF8F);
    pin({15'h0, IRQ}, 16'h1);
    rd(PPAS_OFF_ISTAT, 32'h2);
    rd(PPAS_OFF_INBUF, {24'h0, d[0]});
    rd(PPAS_OFF_STAT, 32'h4E8F);
    for (int i = 1; i < 4; i++) rd(PPAS_OFF_INBUF + 8'(4 * i), {24'h0, d[i]});
    wr(PPAS_OFF_STAT, 32'h0);
    rd(PPAS_OFF_STAT, 32'h008F);
    $display("test input done");
    wr(PPAS_OFF_IMASK, 32'h3);
    wr(PPAS_OFF_OUTBUF + 8'h4, {24'h0, d[1]});
    rd(PPAS_OFF_STAT, 32'h000D);
    host(1'b1, 2'h1, 8'h00);
    rd(PPAS_OFF_STAT, 32'h008F);
    host(1'b1, 2'h1, 8'h00);
    rd(PPAS_OFF_STAT, 32'h00CF);
    pin({IRQ, HOST_DOE_N, 6'h0, HOST_DOUT}, {8'h40, d[1]});
    rd(PPAS_OFF_ISTAT, 32'h4);
    $display("test output done");
    wr(PPAS_OFF_CTRL, 32'h53);
    wr(PPAS_OFF_IMASK, 32'h1);
    host(1'b0, 2'h2, d[2]);
    rd(PPAS_OFF_ISTAT, 32'h0);
    host(1'b0, 2'h3, d[3]);
    wt;
    pin({15'h0, IRQ}, 16'h1);
    rd(PPAS_OFF_ISTAT, 32'h1);
    rd(PPAS_OFF_INBUF + 8'hC, {24'h0, d[3]});
    rd(PPAS_OFF_INBUF + 8'h8, {24'h0, d[2]});
    // Legacy slave with rotating slots: the address lines are ignored
    wr(PPAS_OFF_CTRL, 32'h4C);
    host(1'b0, 2'h3, d[0]);
    host(1'b0, 2'h3, d[1]);
    rd(PPAS_OFF_STAT, 32'h03CF);
    rd(PPAS_OFF_INBUF, {24'h0, d[0]});
    rd(PPAS_OFF_INBUF + 8'h4, {24'h0, d[1]});
    $display("test slave modes done");
    stop_test;
  end
endmodule
`default_nettype wire
